// *** verilog/rst_ctl_consts.vh ***
// constants for the reset, interrupt and low-power control block
`ifndef RST_CTL_CONSTS_VH
`define RST_CTL_CONSTS_VH
// =====================================
// vectors and address map
`define VEC_RESET 16'h07fe
`define VEC_SOFT_TRAP 16'h07fc
`define VEC_EXT 16'h07fa
`define VEC_TIMER 16'h07f8
`define WDOG_CLR_ADDR 16'h07f0
`define WDOG_CLR_BIT 0
`define ROM_LO 16'h0300
`define ROM_HI 16'h07ff
`define RAM_LO 16'h00c0
`define RAM_HI 16'h00ff
// =====================================
// reset values
`define SP_RESET 8'hff
`define BYTE_ZERO 8'h00
// =====================================
// timing, in internal clock cycles
`define STAB_CYCLES 4064
`define HALT_MIN_CYCLES 1
`define CNT_W 12
`define CNT_ONE 12'h001
// =====================================
// stacking step counts and flags mask bit
`define STACK_BYTES 3'h5
`define STEP_ONE 3'h1
`define FLAGS_MASK_BIT 3
`endif

// *** verilog/delay_counter.v ***
// one-shot down counter, loaded on start, used to time stabilization and recovery delays
`timescale 1ns/1ps
module delay_counter #(
	parameter W = 12
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// control
	input wire start,
	input wire [W-1:0] length,
	// status
	output reg busy
);
	// =====================================
	// counter
	reg [W-1:0] count; // cycles still to run
	// load on start, count down to zero while busy
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			count <= {W{1'b0}};
			busy <= 1'b0;
		end else if (start) begin
			count <= length;
			busy <= 1'b1;
		end else if (busy) begin
			// last cycle of the delay frees the cpu
			if (count <= {{(W-1){1'b0}}, 1'b1}) begin
				busy <= 1'b0;
				count <= {W{1'b0}};
			end else begin
				count <= count - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // delay_counter

// *** verilog/reset_interrupt_sleep_control.v ***
// reset, interrupt sequencing and low-power control for an 8-bit cpu core
`timescale 1ns/1ps
`include "rst_ctl_consts.vh"
module reset_interrupt_sleep_control #(
	parameter STAB_CYCLES = `STAB_CYCLES,
	parameter HALT_DELAY = `HALT_MIN_CYCLES,
	parameter STOP_DISABLED = 0,
	parameter WDOG_PRESENT = 1,
	parameter PORTA_IRQ_ON = 1
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// external pins
	input wire reset_pin_n,
	input wire irq_pin_n,
	input wire [3:0] porta_irq_pins,
	// cpu boundary and instruction decode
	input wire insn_done,
	input wire exec_soft_trap,
	input wire exec_return,
	input wire exec_stop,
	input wire exec_wait,
	input wire opcode_fetch,
	input wire [15:0] fetch_addr,
	input wire [7:0] pop_data,
	// cpu register values to stack
	input wire [15:0] pc_in,
	input wire [7:0] x_in,
	input wire [7:0] a_in,
	input wire [7:0] flags_in,
	// memory write port for watchdog clear
	input wire wr_en,
	input wire [15:0] wr_addr,
	input wire [7:0] wr_data,
	// timer and watchdog events
	input wire timer_overflow_flag,
	input wire realtime_irq_flag,
	input wire overflow_irq_enable,
	input wire realtime_irq_enable,
	input wire wdog_timeout,
	// cpu control outputs
	output reg cpu_reset,
	output reg cpu_run,
	output reg osc_run,
	output reg mask_bit,
	output reg ext_irq_enable,
	output reg [7:0] stack_ptr,
	output reg [15:0] vector_addr,
	output reg vector_load,
	output reg push_en,
	output reg [7:0] push_data,
	output reg pop_en,
	output reg [2:0] pop_index,
	// timer, watchdog and port control outputs
	output reg timer_clear,
	output reg timer_sleep_clear,
	output reg wdog_restart,
	output reg port_cfg_clear,
	output reg ext_latch
);
	// =====================================
	// states
	localparam ST_RESET = 3'h0;
	localparam ST_RUN = 3'h1;
	localparam ST_PUSH = 3'h2;
	localparam ST_VECTOR = 3'h3;
	localparam ST_POP = 3'h4;
	localparam ST_STOP = 3'h5;
	localparam ST_WAIT = 3'h6;
	localparam ST_DELAY = 3'h7;
	localparam [`CNT_W-1:0] STAB_LEN = STAB_CYCLES[`CNT_W-1:0];
	localparam [`CNT_W-1:0] HALT_LEN = HALT_DELAY[`CNT_W-1:0];

	reg [2:0] state; // sequencer state
	reg [2:0] step; // stacking byte index
	reg [15:0] pend_vec; // vector chosen for the pending entry
	reg power_up; // still inside the power-up window
	reg irq_prev; // last irq pin level, for edge detect
	reg [3:0] pa_prev; // last port pin level
	reg dly_start; // kicks the delay counter
	reg [`CNT_W-1:0] dly_len; // delay length to load
	reg halt_mode; // stop taken as wait
	wire dly_busy; // delay counter running

	// =====================================
	// helper functions
	// legal fetch space is rom or ram only
	function legal_fetch;
		input [15:0] a;
		begin
			legal_fetch = (a >= `ROM_LO && a <= `ROM_HI) ||
				(a >= `RAM_LO && a <= `RAM_HI);
		end
	endfunction

	// byte pushed at each stacking step, low pc first
	function [7:0] push_byte;
		input [2:0] s;
		begin
			case (s)
				3'h0: push_byte = pc_in[7:0];
				3'h1: push_byte = pc_in[15:8];
				3'h2: push_byte = x_in;
				3'h3: push_byte = a_in;
				default: push_byte = flags_in;
			endcase
		end
	endfunction

	// =====================================
	// reset and interrupt sources
	wire ext_edge = irq_prev & ~irq_pin_n;
	wire pa_edge = (PORTA_IRQ_ON != 0) && |(porta_irq_pins & ~pa_prev);
	wire illegal = opcode_fetch && !legal_fetch(fetch_addr) && state == ST_RUN;
	wire wdog_rst = (WDOG_PRESENT != 0) && wdog_timeout && osc_run;
	// pin low or internal fault forces reset at once
	wire any_reset = ~reset_pin_n | illegal | wdog_rst;
	wire timer_req = (timer_overflow_flag & overflow_irq_enable) |
		(realtime_irq_flag & realtime_irq_enable);
	wire ext_ok = ext_latch & ext_irq_enable & ~mask_bit;
	wire tmr_ok = timer_req & ~mask_bit;

	delay_counter #(
		.W(`CNT_W)
	) u_delay (
		.clk(clk),
		.reset(reset),
		.start(dly_start),
		.length(dly_len),
		.busy(dly_busy)
	);

	// =====================================
	// edge history for the external pins
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_prev <= 1'b1;
			pa_prev <= 4'h0;
		end else begin
			irq_prev <= irq_pin_n;
			pa_prev <= porta_irq_pins;
		end
	end

	// =====================================
	// main sequencer
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= ST_RESET;
			step <= 3'h0;
			pend_vec <= `VEC_RESET;
			power_up <= 1'b1;
			cpu_reset <= 1'b1;
			cpu_run <= 1'b0;
			osc_run <= 1'b1;
			mask_bit <= 1'b1;
			ext_irq_enable <= 1'b1;
			stack_ptr <= `SP_RESET;
			vector_addr <= `VEC_RESET;
			vector_load <= 1'b0;
			push_en <= 1'b0;
			push_data <= `BYTE_ZERO;
			pop_en <= 1'b0;
			pop_index <= 3'h0;
			timer_clear <= 1'b1;
			timer_sleep_clear <= 1'b0;
			wdog_restart <= 1'b1;
			port_cfg_clear <= 1'b1;
			ext_latch <= 1'b0;
			dly_start <= 1'b1;
			dly_len <= STAB_LEN;
			halt_mode <= 1'b0;
		end else begin
			// one-cycle strobes default low
			vector_load <= 1'b0;
			push_en <= 1'b0;
			pop_en <= 1'b0;
			dly_start <= 1'b0;
			timer_sleep_clear <= 1'b0;
			timer_clear <= 1'b0;
			port_cfg_clear <= 1'b0;
			wdog_restart <= 1'b0;
			// latch external edges; the reset clear below wins over a set, the vector-entry clear keeps a new edge
			if (ext_edge || pa_edge) begin
				ext_latch <= 1'b1;
			end
			// watchdog clear write restarts timeout
			if (wr_en && wr_addr == `WDOG_CLR_ADDR && !wr_data[`WDOG_CLR_BIT]) begin
				wdog_restart <= 1'b1;
			end
			if (any_reset) begin
				// abort everything, reinit control state
				state <= ST_RESET;
				cpu_reset <= 1'b1;
				cpu_run <= 1'b0;
				osc_run <= 1'b1;
				mask_bit <= 1'b1;
				ext_irq_enable <= 1'b1;
				stack_ptr <= `SP_RESET;
				halt_mode <= 1'b0;
				ext_latch <= 1'b0;
				timer_clear <= 1'b1;
				wdog_restart <= (WDOG_PRESENT != 0);
				port_cfg_clear <= 1'b1;
				step <= 3'h0;
			end else begin
				case (state)
					ST_RESET: begin
						// power-up waits; start covers the edge before busy shows
						if (!(power_up && (dly_busy || dly_start))) begin
							power_up <= 1'b0;
							cpu_reset <= 1'b0;
							cpu_run <= 1'b1;
							vector_addr <= `VEC_RESET;
							vector_load <= 1'b1;
							state <= ST_RUN;
						end
					end
					ST_RUN: begin
						if (exec_soft_trap) begin
							pend_vec <= `VEC_SOFT_TRAP;
							step <= 3'h0;
							state <= ST_PUSH;
						end else if (exec_return) begin
							step <= 3'h0;
							state <= ST_POP;
						end else if (exec_stop && STOP_DISABLED == 0) begin
							// oscillator halt also stops watchdog
							mask_bit <= 1'b0;
							ext_irq_enable <= 1'b1;
							timer_sleep_clear <= 1'b1;
							osc_run <= 1'b0;
							cpu_run <= 1'b0;
							state <= ST_STOP;
						end else if (exec_wait || exec_stop) begin
							mask_bit <= 1'b0;
							ext_irq_enable <= 1'b1;
							cpu_run <= 1'b0;
							halt_mode <= exec_stop;
							state <= ST_WAIT;
						end else if (insn_done && ext_ok) begin
							pend_vec <= `VEC_EXT;
							step <= 3'h0;
							state <= ST_PUSH;
						end else if (insn_done && tmr_ok) begin
							pend_vec <= `VEC_TIMER;
							step <= 3'h0;
							state <= ST_PUSH;
						end
					end
					ST_PUSH: begin
						// one byte per cycle, stack grows downward
						push_en <= 1'b1;
						push_data <= push_byte(step);
						stack_ptr <= stack_ptr - 8'h01;
						step <= step + `STEP_ONE;
						if (step == `STACK_BYTES - `STEP_ONE) begin
							state <= ST_VECTOR;
						end
					end
					ST_VECTOR: begin
						mask_bit <= 1'b1;
						vector_addr <= pend_vec;
						vector_load <= 1'b1;
						if (pend_vec == `VEC_EXT) begin
							ext_latch <= ext_edge | pa_edge;
						end
						cpu_run <= 1'b1;
						state <= ST_RUN;
					end
					ST_POP: begin
						// flags first, then a, x, pc high, pc low
						pop_en <= 1'b1;
						stack_ptr <= stack_ptr + 8'h01;
						pop_index <= step;
						step <= step + `STEP_ONE;
						if (pop_en && pop_index == 3'h0) begin
							mask_bit <= pop_data[`FLAGS_MASK_BIT];
						end
						if (step == `STACK_BYTES - `STEP_ONE) begin
							state <= ST_RUN;
						end
					end
					ST_STOP: begin
						// only pin edges wake; reset is handled above
						if (ext_edge || pa_edge) begin
							osc_run <= 1'b1;
							dly_start <= 1'b1;
							dly_len <= STAB_LEN;
							state <= ST_DELAY;
						end
					end
					ST_WAIT: begin
						if (ext_latch || ext_edge || pa_edge || timer_req) begin
							dly_start <= halt_mode;
							dly_len <= HALT_LEN;
							state <= ST_DELAY;
						end
					end
					ST_DELAY: begin
						// cpu stays off fetch until counter done
						if (!dly_busy && !dly_start) begin
							cpu_run <= 1'b1;
							halt_mode <= 1'b0;
							pend_vec <= (ext_latch ? `VEC_EXT : `VEC_TIMER);
							step <= 3'h0;
							state <= ST_PUSH;
						end
					end
					default: state <= ST_RESET;
				endcase
			end
		end
	end
endmodule // reset_interrupt_sleep_control

// *** verif/rst_ctl_asserts.sv ***
// port checker for the reset, interrupt and low-power control block
`timescale 1ns/1ps
module rst_ctl_asserts (
	// clock and reset
	input wire clk,
	input wire reset,
	// watched inputs
	input wire reset_pin_n,
	input wire wr_en,
	input wire [15:0] wr_addr,
	input wire [7:0] wr_data,
	input wire opcode_fetch,
	input wire [15:0] fetch_addr,
	// watched outputs
	input wire cpu_reset,
	input wire cpu_run,
	input wire mask_bit,
	input wire ext_irq_enable,
	input wire [7:0] stack_ptr,
	input wire [15:0] vector_addr,
	input wire vector_load,
	input wire push_en,
	input wire pop_en,
	input wire [2:0] pop_index,
	input wire wdog_restart
);
	// ====================
	// one clock domain, async reset gates all checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_reset_state: assert property ($fell(reset) |-> cpu_reset && !cpu_run && mask_bit
		&& ext_irq_enable && stack_ptr == 8'hff) else $error("reset state wrong");
	a_stack_five: assert property ($rose(push_en) |-> push_en [*5] ##1 (!push_en
		&& vector_load)) else $error("stacking not five bytes then vector");
	a_vec_masked: assert property (vector_load |-> mask_bit && (vector_addr inside
		{16'h07f8, 16'h07fa, 16'h07fc, 16'h07fe})) else $error("vector load bad");
	a_pop_five: assert property ($rose(pop_en) |-> pop_index == 3'h0 ##0 pop_en [*5]
		##1 !pop_en) else $error("unstack not five bytes");
	a_pop_order: assert property (pop_en && $past(pop_en) |->
		pop_index == $past(pop_index) + 3'h1) else $error("unstack order");
	a_pin_reset: assert property (!reset_pin_n [*2] |-> ##[0:2] cpu_reset)
		else $error("pin low gave no reset");
	a_illegal_fetch: assert property (opcode_fetch && cpu_run && !(fetch_addr
		inside {[16'h0300:16'h07ff], [16'h00c0:16'h00ff]}) |-> ##[1:2] cpu_reset)
		else $error("illegal fetch gave no reset");
	a_run_held: assert property (cpu_reset |-> !cpu_run)
		else $error("cpu runs in reset");
	a_wdog_clear: assert property (wr_en && wr_addr == 16'h07f0 && !wr_data[0]
		|=> wdog_restart) else $error("watchdog not restarted");
endmodule // rst_ctl_asserts

// *** verif/src_model.sv ***
// reset pin and external interrupt pin sources
`timescale 1ns/1ps
module src_model (
	// clock
	input wire clk,
	// pins
	output reg reset_pin_n,
	output reg irq_pin_n,
	output reg [3:0] porta_irq_pins
);
	// ====================
	// idle: reset and irq released high, port lines low
	initial begin
		reset_pin_n = 1'h1;
		irq_pin_n = 1'h1;
		porta_irq_pins = 4'h0;
	end
	// reset low for n cycles, never under two so the minimum width holds
	task pin_reset(input integer n);
		begin
			@(posedge clk);
			#1 reset_pin_n = 1'h0;
			repeat (n < 2 ? 2 : n) @(posedge clk);
			#1 reset_pin_n = 1'h1;
		end
	endtask
	// set the interrupt pins just after the next edge
	task drive(input i, input [3:0] p);
		begin
			@(posedge clk);
			#1 irq_pin_n = i;
			porta_irq_pins = p;
		end
	endtask
endmodule // src_model

// *** verif/tb_reset_interrupt_sleep_control.sv ***
// self-checking bench for the reset, interrupt and low-power control block
`timescale 1ns/1ps
module tb_reset_interrupt_sleep_control;
	// ====================
	// stimulus, all moved 1 ns after the rising edge
	reg clk = 1'h0, reset = 1'h1, insn_done = 1'h0, exec_soft_trap = 1'h0;
	reg exec_return = 1'h0, exec_stop = 1'h0, exec_wait = 1'h0, opcode_fetch = 1'h0;
	reg wr_en = 1'h0, timer_overflow_flag = 1'h0, realtime_irq_flag = 1'h0;
	reg overflow_irq_enable = 1'h0, realtime_irq_enable = 1'h0, wdog_timeout = 1'h0;
	reg [15:0] fetch_addr = 16'h0300, wr_addr = 16'h0000, pc_in = 16'h1234;
	reg [7:0] pop_data = 8'h00, x_in = 8'h56, a_in = 8'h78, flags_in = 8'hc4;
	reg [7:0] wr_data = 8'h00;
	wire reset_pin_n, irq_pin_n, cpu_reset, cpu_run, osc_run, mask_bit, ext_irq_enable;
	wire vector_load, push_en, pop_en, timer_clear, timer_sleep_clear, wdog_restart;
	wire port_cfg_clear, ext_latch;
	wire [3:0] porta_irq_pins;
	wire [7:0] stack_ptr, push_data;
	wire [15:0] vector_addr;
	wire [2:0] pop_index;
	integer num_errors = 0, tests_run = 0, cyc, np, k;
	reg [7:0] q [0:4]; // bytes seen on the stack port
	// short delay keeps power-up and stop exit runs brief
	reset_interrupt_sleep_control #(.STAB_CYCLES(8)) dut_u (.clk(clk),
		.reset(reset), .reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n),
		.porta_irq_pins(porta_irq_pins), .insn_done(insn_done),
		.exec_soft_trap(exec_soft_trap), .exec_return(exec_return),
		.exec_stop(exec_stop), .exec_wait(exec_wait), .opcode_fetch(opcode_fetch),
		.fetch_addr(fetch_addr), .pop_data(pop_data), .pc_in(pc_in),
		.x_in(x_in), .a_in(a_in), .flags_in(flags_in), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data),
		.timer_overflow_flag(timer_overflow_flag),
		.realtime_irq_flag(realtime_irq_flag),
		.overflow_irq_enable(overflow_irq_enable),
		.realtime_irq_enable(realtime_irq_enable), .wdog_timeout(wdog_timeout),
		.cpu_reset(cpu_reset), .cpu_run(cpu_run), .osc_run(osc_run),
		.mask_bit(mask_bit), .ext_irq_enable(ext_irq_enable),
		.stack_ptr(stack_ptr), .vector_addr(vector_addr),
		.vector_load(vector_load), .push_en(push_en), .push_data(push_data),
		.pop_en(pop_en), .pop_index(pop_index), .timer_clear(timer_clear),
		.timer_sleep_clear(timer_sleep_clear), .wdog_restart(wdog_restart),
		.port_cfg_clear(port_cfg_clear), .ext_latch(ext_latch));
	src_model src_u (.clk(clk), .reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n),
		.porta_irq_pins(porta_irq_pins));
	always #5 clk = ~clk;
	// ====================
	// helpers
	task step;
		begin
			@(posedge clk);
			#1;
		end
	endtask
	task chk(input [15:0] g, input [15:0] e);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0t got %h expected %h", $time, g, e);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("errors %0d checks %0d", num_errors, tests_run);
			if (num_errors == 0 && tests_run > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// wait for a vector load, gathering stacked bytes; bounded
	task to_vec(input [15:0] e);
		begin
			np = 0;
			for (cyc = 0; cyc < 200 && !vector_load; cyc = cyc + 1) begin
				if (push_en && np < 5) begin
					q[np] = push_data;
					np = np + 1;
				end
				step;
			end
			if (!vector_load) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0t no vector load", $time);
				end_of_test;
			end
			chk(vector_addr, e);
			step;
		end
	endtask
	task ret(input [7:0] f);
		begin
			pop_data = f;
			exec_return = 1'h1;
			step;
			exec_return = 1'h0;
			np = 0;
			for (k = 0; k < 12; k = k + 1) begin
				if (pop_en) begin
					chk(pop_index, np);
					np = np + 1;
				end
				step;
			end
			chk(np, 5);
			chk(mask_bit, f[3]);
		end
	endtask
	task boundary;
		begin
			insn_done = 1'h1;
			step;
			insn_done = 1'h0;
		end
	endtask
	// ====================
	// scenarios
	task t_power;
		begin
			to_vec(16'h07fe);
			chk(cyc >= 8, 1);
			chk({stack_ptr, mask_bit, ext_irq_enable, cpu_run}, 16'h07ff);
		end
	endtask
	task t_wait;
		begin
			exec_wait = 1'h1;
			step;
			exec_wait = 1'h0;
			step;
			step;
			chk({mask_bit, ext_irq_enable, osc_run}, 3'h3);
			src_u.drive(1'h0, 4'h0);
			to_vec(16'h07fa);
			src_u.drive(1'h1, 4'h0);
			chk({q[0], q[1]}, 16'h3412);
			chk({q[2], q[3]}, 16'h5678);
			chk(q[4], 8'hc4);
		end
	endtask
	task t_prio;
		begin
			ret(8'h00);
			timer_overflow_flag = 1'h1;
			overflow_irq_enable = 1'h1;
			src_u.drive(1'h0, 4'h0);
			src_u.drive(1'h1, 4'h0);
			chk(ext_latch, 1);
			boundary;
			to_vec(16'h07fa);
			chk(ext_latch, 0);
			ret(8'h00);
			boundary;
			to_vec(16'h07f8);
			timer_overflow_flag = 1'h0;
		end
	endtask
	task t_trap;
		begin
			exec_soft_trap = 1'h1;
			step;
			exec_soft_trap = 1'h0;
			to_vec(16'h07fc);
			ret(8'h08);
		end
	endtask
	task t_stop;
		begin
			exec_stop = 1'h1;
			step;
			exec_stop = 1'h0;
			chk(timer_sleep_clear, 1);
			step;
			step;
			chk({osc_run, mask_bit, ext_irq_enable}, 3'h1);
			src_u.drive(1'h1, 4'h4);
			to_vec(16'h07fa);
			// eight stabilization cycles come on top of the stacking time
			chk(cyc >= 14, 1);
			src_u.drive(1'h1, 4'h0);
		end
	endtask
	task t_wdog;
		begin
			wr_addr = 16'h07f0;
			for (k = 0; k < 2; k = k + 1) begin
				wr_data = k[7:0];
				wr_en = 1'h1;
				step;
				wr_en = 1'h0;
				chk(wdog_restart, k == 0);
				step;
			end
		end
	endtask
	task t_resets;
		begin
			fetch_addr = 16'h0200;
			opcode_fetch = 1'h1;
			step;
			opcode_fetch = 1'h0;
			chk({timer_clear, port_cfg_clear, wdog_restart, cpu_reset}, 4'hf);
			chk(stack_ptr, 8'hff);
			to_vec(16'h07fe);
			src_u.pin_reset(4);
			to_vec(16'h07fe);
			chk(stack_ptr, 8'hff);
		end
	endtask
	// ====================
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		#1 reset = 1'h0;
		t_power;
		t_wait;
		t_prio;
		t_trap;
		t_stop;
		t_wdog;
		t_resets;
		end_of_test;
	end
endmodule // tb_reset_interrupt_sleep_control
bind reset_interrupt_sleep_control rst_ctl_asserts chk_u (.clk(clk), .reset(reset),
	.reset_pin_n(reset_pin_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
	.opcode_fetch(opcode_fetch), .fetch_addr(fetch_addr), .cpu_reset(cpu_reset),
	.cpu_run(cpu_run), .mask_bit(mask_bit), .ext_irq_enable(ext_irq_enable),
	.stack_ptr(stack_ptr), .vector_addr(vector_addr), .vector_load(vector_load),
	.push_en(push_en), .pop_en(pop_en), .pop_index(pop_index),
	.wdog_restart(wdog_restart));
